// ### rtl/mrs_reset_seq.sv
// How it works
// [R1] pin high two machine cycles or longer starts a full internal reset
// [R2] address-latch and program-store strobes are high during reset
// [R3] watchdog request drives the pin high for exactly three machine cycles
// [R4] bus wake-up in power-down drives the pin high for 6144 machine cycles
// [R5] wake-up reset spares the bus controller; everything else is reset
// [R6] internal reset acts whatever level the pin shows
// [R7] reset never touches main or auxiliary RAM contents
// [R8] listed registers load zeros, ports ones, stack 07, bus status 0C
// [R9] undefined registers are left alone; power-control and enables clear low bits
// [R10] watchdog overflow ends idle and resets like an external reset
// [R11] wake-up only counts when global and bus interrupt enables are set
// [R12] internal pulse stretched past 8192 machine cycles resets the bus controller
// [R13] lengths count twelve-clock machine cycles; pin synchronised, sampled once per cycle
`timescale 1ns/1ns
module mrs_reset_seq #(
    parameter logic [13:0] WAKE_LEN    = mrs_pkg::WAKE_MC,
    parameter logic [13:0] STRETCH_LEN = mrs_pkg::STRETCH_MC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       clkEn,
    // reset pin, three-signal form
    input  wire logic       rstPinIn,
    output logic            rstPinOut,
    output logic            rstPinOe,
    // reset sources
    input  wire logic       watchdogOverflow,
    input  wire logic       busWakeup,
    // strobes from the core
    input  wire logic       aleIn,
    input  wire logic       psenIn,
    // software register writes
    input  wire logic       regWrEn,
    input  wire logic [2:0] regSel,
    input  wire logic [7:0] regWrData,
    // reset outputs
    output logic            coreReset,
    output logic            busCtrlReset,
    output logic            ramWriteInhibit,
    // strobe pins
    output logic            addrLatchStrobe,
    output logic            programStoreStrobe,
    // register images
    output logic [7:0]      accumulatorReg,
    output logic [7:0]      stackPointerReg,
    output logic [7:0]      portLatchReg,
    output logic [7:0]      busStatusReg,
    output logic [7:0]      powerControlReg,
    output logic [7:0]      interruptEnableLow,
    output mrs_pkg::mrs_state_t seqState
);
    typedef struct packed {
        mrs_pkg::mrs_state_t st;
        logic [13:0]         mcCnt;
        logic [1:0]          hiCnt;
        logic                wdPend;
        logic                wkPend;
        logic                coreRst;
        logic                busRst;
        logic                drive;
        logic                ale;
        logic                program_store_strobe;
        logic [7:0]          acc;
        logic [7:0]          sp;
        logic [7:0]          port;
        logic [7:0]          bsr;
        logic [7:0]          power_control_reg;
        logic [7:0]          ien;
    } mrs_seq_t;

    mrs_seq_t r_reg;
    mrs_seq_t r_next;
    logic     wakeOk;

    mrs_tick_if smp ();

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser and machine-cycle timebase
    mrs_pin_filter u_filter (
        .clk      (clk),
        .arst_n   (arst_n),
        .clkEn    (clkEn),
        .rstPinIn (rstPinIn),
        .smp      (smp)
    );

    // wake-up accepted only in power-down with both enables set
    assign wakeOk = r_reg.power_control_reg[mrs_pkg::POWER_CONTROL_REG_PD]
                  & r_reg.ien[mrs_pkg::IEN_GLOBAL]
                  & r_reg.ien[mrs_pkg::IEN_BUS];                       // [R11]

    ////////////////////////////////////////////////////////////////////////////
    // sequencer, pending events, strobes and register images
    always_comb begin
        r_next = r_reg;
        // events latch until the sequencer takes them; the watchdog wins and drops a pending wake
        if (watchdogOverflow) begin
            r_next.wdPend = 1'b1;                                      // [R10]
        end
        if (busWakeup && wakeOk) begin
            r_next.wkPend = 1'b1;                                      // [R11]
        end

        if (smp.tick) begin
            case (r_reg.st)
                mrs_pkg::MRS_RUN: begin
                    if (r_reg.wdPend) begin
                        r_next.st      = mrs_pkg::MRS_WDOG;
                        r_next.wdPend  = watchdogOverflow;
                        r_next.wkPend  = 1'b0;
                        r_next.mcCnt   = 14'h0001;
                        r_next.drive   = 1'b1;                         // [R3]
                        r_next.coreRst = 1'b1;                         // [R6] [R10]
                        r_next.busRst  = 1'b1;                         // [R10]
                    end else if (r_reg.wkPend) begin
                        r_next.st      = mrs_pkg::MRS_WAKE;
                        r_next.wkPend  = busWakeup && wakeOk;
                        r_next.mcCnt   = 14'h0001;
                        r_next.drive   = 1'b1;                         // [R4]
                        r_next.coreRst = 1'b1;                         // [R5] [R6]
                    end else if (smp.pinLevel) begin
                        if (r_reg.hiCnt == mrs_pkg::EXT_MIN_MC - 2'h1) begin
                            r_next.st      = mrs_pkg::MRS_EXT;
                            r_next.coreRst = 1'b1;                     // [R1]
                            r_next.busRst  = 1'b1;                     // [R1]
                        end else begin
                            r_next.hiCnt = r_reg.hiCnt + 2'h1;         // [R1]
                        end
                    end else begin
                        // a low sample ends the power-up reset as well
                        r_next.hiCnt   = 2'h0;
                        r_next.coreRst = 1'b0;
                        r_next.busRst  = 1'b0;
                    end
                end
                mrs_pkg::MRS_EXT: begin
                    if (!smp.pinLevel) begin
                        r_next.st      = mrs_pkg::MRS_RUN;
                        r_next.hiCnt   = 2'h0;
                        r_next.coreRst = 1'b0;
                        r_next.busRst  = 1'b0;
                    end
                end
                mrs_pkg::MRS_WDOG, mrs_pkg::MRS_WAKE: begin
                    r_next.mcCnt = r_reg.mcCnt + 14'h0001;
                    if ((r_reg.st == mrs_pkg::MRS_WDOG && r_reg.mcCnt == mrs_pkg::WDOG_MC)
                        || (r_reg.st == mrs_pkg::MRS_WAKE && r_reg.mcCnt == WAKE_LEN)) begin
                        r_next.st    = mrs_pkg::MRS_TAIL;
                        r_next.drive = 1'b0;                           // [R3] [R4]
                    end
                end
                mrs_pkg::MRS_TAIL: begin
                    // an external capacitor may hold the pin up after release
                    if (!smp.pinLevel) begin
                        r_next.st      = mrs_pkg::MRS_RUN;
                        r_next.hiCnt   = 2'h0;
                        r_next.coreRst = 1'b0;
                        r_next.busRst  = 1'b0;
                    end else begin
                        if (r_reg.mcCnt != STRETCH_LEN) begin
                            r_next.mcCnt = r_reg.mcCnt + 14'h0001;
                        end else begin
                            r_next.busRst = 1'b1;                      // [R12]
                        end
                    end
                end
                default: begin
                    r_next.st      = mrs_pkg::MRS_RUN;
                    r_next.drive   = 1'b0;
                    r_next.coreRst = 1'b0;
                    r_next.busRst  = 1'b0;
                end
            endcase
        end

        // strobes forced high while the core is in reset
        r_next.ale  = r_next.coreRst | aleIn;                          // [R2]
        r_next.program_store_strobe = r_next.coreRst | psenIn;                         // [R2]

        // software writes, blocked while the target is in reset
        if (regWrEn && !r_reg.coreRst) begin
            case (regSel)
                mrs_pkg::SEL_ACC:  r_next.acc  = regWrData;
                mrs_pkg::SEL_SP:   r_next.sp   = regWrData;
                mrs_pkg::SEL_PORT: r_next.port = regWrData;
                mrs_pkg::SEL_POWER_CONTROL_REG: r_next.power_control_reg = regWrData;
                mrs_pkg::SEL_IEN:  r_next.ien  = regWrData;
                default: ;
            endcase
        end
        if (regWrEn && !r_reg.busRst && regSel == mrs_pkg::SEL_BSR) begin
            r_next.bsr = regWrData;
        end

        // reset values; undefined bits keep what they held
        if (r_next.coreRst) begin
            r_next.acc  = mrs_pkg::RST_ZERO;                           // [R8]
            r_next.sp   = mrs_pkg::RST_SP;                             // [R8]
            r_next.port = mrs_pkg::RST_PORT;                           // [R8]
            r_next.power_control_reg = r_next.power_control_reg & mrs_pkg::POWER_CONTROL_REG_KEEP;            // [R9]
            r_next.ien  = mrs_pkg::RST_ZERO;                           // [R8] [R9]
        end
        if (r_next.busRst) begin
            r_next.bsr = mrs_pkg::RST_BSR;                             // [R5] [R8]
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg         <= '0;
            r_reg.st      <= mrs_pkg::MRS_RUN;
            r_reg.coreRst <= 1'b1;
            r_reg.busRst  <= 1'b1;
            r_reg.ale     <= 1'b1;
            r_reg.program_store_strobe    <= 1'b1;
            r_reg.sp      <= mrs_pkg::RST_SP;
            r_reg.port    <= mrs_pkg::RST_PORT;
            r_reg.bsr     <= mrs_pkg::RST_BSR;
        end else if (clkEn) begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register; the pin data is tied high
    assign rstPinOut          = 1'b1;                  // pull-up only drives high
    assign rstPinOe           = r_reg.drive;           // [R3] [R4]
    assign coreReset          = r_reg.coreRst;         // [R6]
    assign busCtrlReset       = r_reg.busRst;          // [R5]
    assign ramWriteInhibit    = r_reg.coreRst;         // [R7]
    assign addrLatchStrobe    = r_reg.ale;
    assign programStoreStrobe = r_reg.program_store_strobe;
    assign accumulatorReg     = r_reg.acc;
    assign stackPointerReg    = r_reg.sp;
    assign portLatchReg       = r_reg.port;
    assign busStatusReg       = r_reg.bsr;
    assign powerControlReg    = r_reg.power_control_reg;
    assign interruptEnableLow = r_reg.ien;
    assign seqState           = r_reg.st;
endmodule // mrs_reset_seq

// ### rtl/mrs_pkg.sv
package mrs_pkg;
    // timebase: one machine cycle is twelve oscillator clocks
    localparam logic [3:0]  MC_CLKS     = 4'hC;
    localparam logic [1:0]  EXT_MIN_MC  = 2'h2;      // least external high time
    localparam logic [13:0] WDOG_MC     = 14'h0003;  // watchdog pin drive length
    localparam logic [13:0] WAKE_MC     = 14'h1800;  // wake-up pin drive length
    localparam logic [13:0] STRETCH_MC  = 14'h2000;  // stretched pulse limit

    // register select codes for the software write port
    localparam logic [2:0]  SEL_ACC     = 3'h0;
    localparam logic [2:0]  SEL_SP      = 3'h1;
    localparam logic [2:0]  SEL_PORT    = 3'h2;
    localparam logic [2:0]  SEL_BSR     = 3'h3;
    localparam logic [2:0]  SEL_POWER_CONTROL_REG    = 3'h4;
    localparam logic [2:0]  SEL_IEN     = 3'h5;

    // reset values
    localparam logic [7:0]  RST_ZERO    = 8'h00;
    localparam logic [7:0]  RST_PORT    = 8'hFF;
    localparam logic [7:0]  RST_SP      = 8'h07;
    localparam logic [7:0]  RST_BSR     = 8'h0C;
    localparam logic [7:0]  POWER_CONTROL_REG_KEEP   = 8'h40;     // bit six survives reset

    // field positions
    localparam int          POWER_CONTROL_REG_PD     = 1;
    localparam int          IEN_GLOBAL  = 7;
    localparam int          IEN_BUS     = 5;

    // sequencer states
    typedef enum logic [2:0] {
        MRS_RUN   = 3'b000,
        MRS_EXT   = 3'b001,
        MRS_WDOG  = 3'b010,
        MRS_WAKE  = 3'b011,
        MRS_TAIL  = 3'b100
    } mrs_state_t;
endpackage

// ### rtl/mrs_tick_if.sv
`timescale 1ns/1ns
interface mrs_tick_if;
    logic tick;       // one-clock pulse per machine cycle
    logic pinLevel;   // filtered pin level, updated on tick
    modport src (output tick, output pinLevel);
    modport snk (input tick, input pinLevel);
endinterface

// ### rtl/mrs_pin_filter.sv
`timescale 1ns/1ns
module mrs_pin_filter (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic clkEn,
    // reset pin level
    input  wire logic rstPinIn,
    // machine-cycle sample
    mrs_tick_if.src   smp
);
    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic [3:0] pre;
        logic       tick;
        logic       level;
    } mrs_flt_t;

    mrs_flt_t r_reg;
    mrs_flt_t r_next;

    ////////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser, prescaler and once-per-machine-cycle sample
    always_comb begin
        r_next       = r_reg;
        r_next.sync1 = rstPinIn;
        r_next.sync2 = r_reg.sync1;
        r_next.tick  = 1'b0;
        if (r_reg.pre == mrs_pkg::MC_CLKS - 4'h1) begin
            r_next.pre   = 4'h0;
            r_next.tick  = 1'b1;                 // [R13]
            r_next.level = r_reg.sync2;          // [R13]
        end else begin
            r_next.pre = r_reg.pre + 4'h1;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
        end else if (clkEn) begin
            r_reg <= r_next;
        end
    end

    assign smp.tick     = r_reg.tick;
    assign smp.pinLevel = r_reg.level;
endmodule // mrs_pin_filter

// ### verif/mrs_reset_monitor.sv
`timescale 1ns/1ns
module mrs_reset_monitor #(
    parameter logic [13:0] WAKE_LEN = mrs_pkg::WAKE_MC
) (
    // clock and reset
    input wire logic                clk,
    input wire logic                arst_n,
    // pin and resets
    input wire logic                rstPinOut,
    input wire logic                rstPinOe,
    input wire logic                coreReset,
    input wire logic                busCtrlReset,
    input wire logic                ramWriteInhibit,
    input wire logic                addrLatchStrobe,
    input wire logic                programStoreStrobe,
    // register images
    input wire logic [7:0]          accumulatorReg,
    input wire logic [7:0]          stackPointerReg,
    input wire logic [7:0]          portLatchReg,
    input wire logic [7:0]          busStatusReg,
    input wire logic [7:0]          powerControlReg,
    input wire logic [7:0]          interruptEnableLow,
    input wire mrs_pkg::mrs_state_t seqState
);
    localparam int WAKE_CLK = int'(WAKE_LEN) * 12;
    logic [17:0]         oeLen_reg;
    mrs_pkg::mrs_state_t kind_reg;
    ////////////////////////////////////////
    // length of the current pin drive and the state that started it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            oeLen_reg <= '0;
            kind_reg  <= mrs_pkg::MRS_RUN;
        end else begin
            oeLen_reg <= rstPinOe ? oeLen_reg + 18'd1 : '0;
            if (rstPinOe && oeLen_reg == '0) kind_reg <= seqState;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_wdog_go; $rose(rstPinOe) && seqState == mrs_pkg::MRS_WDOG; endsequence
    sequence s_wake_go; $rose(rstPinOe) && seqState == mrs_pkg::MRS_WAKE; endsequence
    sequence s_drive_end; $fell(rstPinOe); endsequence
    a_strobe_high: assert property (coreReset |-> addrLatchStrobe && programStoreStrobe)
        else $error("strobe low in reset");
    a_ram_kept: assert property (ramWriteInhibit == coreReset)
        else $error("ram inhibit differs from reset");
    a_pin_pullup: assert property (rstPinOe |-> rstPinOut)
        else $error("pin driven low");
    a_wdog_len: assert property ((s_drive_end ##0 kind_reg == mrs_pkg::MRS_WDOG) |->
        oeLen_reg == 18'd36)
        else $error("watchdog drive length wrong");
    a_wake_len: assert property ((s_drive_end ##0 kind_reg == mrs_pkg::MRS_WAKE) |->
        oeLen_reg == 18'(WAKE_CLK))
        else $error("wake drive length wrong");
    a_wdog_full: assert property (s_wdog_go |->
        coreReset && busCtrlReset ##1 rstPinOe[*8])
        else $error("watchdog reset incomplete");
    a_wake_spare: assert property (seqState == mrs_pkg::MRS_WAKE |->
        coreReset && !busCtrlReset)
        else $error("wake reset hit bus controller");
    a_wake_gate: assert property (s_wake_go |->
        $past(powerControlReg[mrs_pkg::POWER_CONTROL_REG_PD]
        && interruptEnableLow[mrs_pkg::IEN_GLOBAL] && interruptEnableLow[mrs_pkg::IEN_BUS]))
        else $error("wake taken while not allowed");
    a_reg_loads: assert property (coreReset && $past(coreReset) |->
        accumulatorReg == 8'h00
        && stackPointerReg == 8'h07 && portLatchReg == 8'hFF && interruptEnableLow == 8'h00
        && (powerControlReg & ~mrs_pkg::POWER_CONTROL_REG_KEEP) == 8'h00)
        else $error("reset values not loaded");
    a_bus_loads: assert property (busCtrlReset && $past(busCtrlReset) |->
        busStatusReg == 8'h0C)
        else $error("bus status not loaded");
endmodule // mrs_reset_monitor
bind mrs_reset_seq mrs_reset_monitor #(.WAKE_LEN(WAKE_LEN)) u_mrs_reset_monitor (
    .clk(clk), .arst_n(arst_n), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .coreReset(coreReset), .busCtrlReset(busCtrlReset), .ramWriteInhibit(ramWriteInhibit),
    .addrLatchStrobe(addrLatchStrobe), .programStoreStrobe(programStoreStrobe),
    .accumulatorReg(accumulatorReg), .stackPointerReg(stackPointerReg),
    .portLatchReg(portLatchReg), .busStatusReg(busStatusReg),
    .powerControlReg(powerControlReg), .interruptEnableLow(interruptEnableLow),
    .seqState(seqState));

// ### verif/mrs_pin_model.sv
`timescale 1ns/1ns
module mrs_pin_model (
    // clock
    input wire logic       clk,
    // device side of the pin
    input wire logic       pinOe,
    input wire logic       pinOut,
    // board side
    input wire logic       extHigh,
    input wire logic [7:0] capMc,
    output logic           pin
);
    int capCnt = 0;
    // board capacitor keeps the pin high after the device lets go
    always @(posedge clk) begin
        if (pinOe) capCnt <= int'(capMc) * 12;
        else if (capCnt > 0) capCnt <= capCnt - 1;
    end
    // released pin falls to the pull-down level
    assign pin = (pinOe & pinOut) | extHigh | (capCnt != 0);
endmodule // mrs_pin_model

// ### verif/tb.sv
`timescale 1ns/1ns
module tb;
    logic                clk, arst_n, rstPin, rstPinOut, rstPinOe, watchdogOverflow;
    logic                busWakeup, regWrEn, coreReset, busCtrlReset, ramWriteInhibit;
    logic                ale, program_store_strobe, extHigh, sawCore, sawBus, clkEn;
    logic [7:0]          capMc, regWrData, acc, sp, port, bsr, power_control_reg, ien;
    logic [2:0]          regSel;
    mrs_pkg::mrs_state_t seqState;
    logic [7:0]          mdl [6];
    int                  error_cnt, samples_checked, seed, n, len;
    ////////////////////////////////////////
    mrs_reset_seq #(.WAKE_LEN(14'h0014), .STRETCH_LEN(14'h001E)) u_mrs_reset_seq (
        .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .rstPinIn(rstPin),
        .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .watchdogOverflow(watchdogOverflow),
        .busWakeup(busWakeup), .aleIn(1'b0), .psenIn(1'b0), .regWrEn(regWrEn),
        .regSel(regSel), .regWrData(regWrData), .coreReset(coreReset),
        .busCtrlReset(busCtrlReset), .ramWriteInhibit(ramWriteInhibit),
        .addrLatchStrobe(ale), .programStoreStrobe(program_store_strobe), .accumulatorReg(acc),
        .stackPointerReg(sp), .portLatchReg(port), .busStatusReg(bsr),
        .powerControlReg(power_control_reg), .interruptEnableLow(ien), .seqState(seqState));
    mrs_pin_model u_mrs_pin_model (.clk(clk), .pinOe(rstPinOe), .pinOut(rstPinOut),
        .extHigh(extHigh), .capMc(capMc), .pin(rstPin));
    ////////////////////////////////////////
    // clock and reset observers
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (coreReset === 1'b1) sawCore <= 1'b1;
        if (busCtrlReset === 1'b1) sawBus <= 1'b1;
    end
    ////////////////////////////////////////
    task chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task cmpAll();
        chk("acc", 18'(acc), 18'(mdl[0]));
        chk("sp", 18'(sp), 18'(mdl[1]));
        chk("port", 18'(port), 18'(mdl[2]));
        chk("bsr", 18'(bsr), 18'(mdl[3]));
        chk("power_control_reg", 18'(power_control_reg), 18'(mdl[4]));
        chk("ien", 18'(ien), 18'(mdl[5]));
    endtask
    task wr(input logic [2:0] s, input logic [7:0] d);
        regSel = s;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
        if (s < 3'h6) mdl[s] = d;
        // let one edge pass with the strobe low before the next write
        @(negedge clk);
    endtask
    task mdlRst(input logic bus);
        mdl[0] = 8'h00;
        mdl[1] = 8'h07;
        mdl[2] = 8'hFF;
        if (bus) mdl[3] = 8'h0C;
        mdl[4] = mdl[4] & 8'h40;
        mdl[5] = 8'h00;
    endtask
    task waitRun();
        repeat (40) @(negedge clk);
        n = 0;
        while ((coreReset !== 1'b0 || seqState !== mrs_pkg::MRS_RUN) && n < 20000) begin
            @(negedge clk);
            n++;
        end
        chk("settle", 18'(n < 20000), 18'd1);
    endtask
    task cntOe();
        n = 0;
        while (rstPinOe !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        len = 0;
        while (rstPinOe === 1'b1 && len < 400) begin
            @(negedge clk);
            len++;
        end
    endtask
    task pulse(input int w);
        if (w) watchdogOverflow = 1'b1;
        else busWakeup = 1'b1;
        @(negedge clk);
        watchdogOverflow = 1'b0;
        busWakeup = 1'b0;
    endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // watchdog on the whole run
    initial begin
        #300000;
        error_cnt++;
        print_verdict();
    end
    // main sequence
    initial begin
        seed = 32'he282;
        clkEn = 1'b1;
        {arst_n, watchdogOverflow, busWakeup, regWrEn, extHigh} = '0;
        {regSel, regWrData, capMc} = '0;
        {mdl[3], mdl[4]} = '0;
        repeat (10) @(negedge clk);
        chk("strobes", 18'(ale & program_store_strobe & ramWriteInhibit), 18'd1);
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        waitRun();
        mdlRst(1'b1);
        cmpAll();
        $display("test reset done");
        for (int i = 0; i < 8; i++) wr(3'(i), 8'($random(seed)));
        cmpAll();
        $display("test writes done");
        sawCore = 1'b0;
        sawBus = 1'b0;
        // a long pin pulse while the clock enable is low leaves no trace
        clkEn = 1'b0;
        extHigh = 1'b1;
        repeat (30) @(negedge clk);
        extHigh = 1'b0;
        repeat (4) @(negedge clk);
        clkEn = 1'b1;
        // a pulse shorter than one machine cycle is sampled once at most
        extHigh = 1'b1;
        repeat (11) @(negedge clk);
        extHigh = 1'b0;
        repeat (40) @(negedge clk);
        chk("short", 18'(sawCore | sawBus), 18'd0);
        cmpAll();
        $display("test short done");
        extHigh = 1'b1;
        repeat (24) @(negedge clk);
        extHigh = 1'b0;
        waitRun();
        chk("ext", 18'(sawCore & sawBus), 18'd1);
        mdlRst(1'b1);
        cmpAll();
        $display("test ext done");
        wr(3'h0, 8'($random(seed)));
        pulse(1);
        cntOe();
        chk("wdog", 18'(len), 18'd36);
        waitRun();
        mdlRst(1'b1);
        cmpAll();
        $display("test wdog done");
        wr(3'h4, 8'h02);
        wr(3'h5, 8'h20);
        sawCore = 1'b0;
        pulse(0);
        repeat (40) @(negedge clk);
        chk("gate", 18'(sawCore), 18'd0);
        $display("test gate done");
        for (int c = 0; c < 2; c++) begin
            capMc = c ? 8'd20 : 8'd0;
            wr(3'h3, 8'($random(seed)));
            wr(3'h4, 8'h02);
            wr(3'h5, 8'hA0);
            sawBus = 1'b0;
            pulse(0);
            cntOe();
            chk("wake", 18'(len), 18'd240);
            waitRun();
            chk("bus", 18'(sawBus), 18'(c));
            mdlRst(1'(c));
            cmpAll();
            $display("test wake %0d done", c);
        end
        print_verdict();
    end
endmodule // tb
